// [rtl/ucr_pin_route.sv]
// serial channel 0 alternate pin routing with its port registers
//
// Our own choice: the plain strobed port.
`include "ucr_params.svh"

module ucr_pin_route #(
  parameter int ADDR_W = `UCR_ADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic serial0_transmit_line_i,
  output logic serial0_receive_line_o,
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o,
  input wire logic rx_pin_i,
  output logic rx_pin_o,
  output logic rx_pin_oe_o
);
  localparam int TXB = `UCR_TX_BIT;
  localparam int RXB = `UCR_RX_BIT;

  logic [7:0] port4_output_data;
  logic [7:0] port4_direction;
  logic [7:0] port4_drive_config_low;
  logic [7:0] port4_drive_config_high;
  logic [7:0] port4_function_select_low;
  logic [7:0] port4_function_select_high;
  logic [7:0] port5_output_data;
  logic [7:0] port5_direction;
  logic [7:0] port5_drive_config_low;
  logic [7:0] port5_drive_config_high;
  logic [7:0] port5_function_select_low;
  logic [7:0] port5_function_select_high;
  logic tx_sel;
  logic rx_sel;
  logic tx_pad;
  logic tx_pad_oe;
  logic rx_pad_sync;
  logic rx_line;
  logic tx_pin_sync;
  logic [7:0] next_rdata;
  logic [7:0] status;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // port 4 registers (full 8 bits)
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port4_output_data <= `UCR_P4_RESET;
      port4_direction <= `UCR_P4_DIR_RESET;
      port4_drive_config_low <= `UCR_P4_RESET;
      port4_drive_config_high <= `UCR_P4_RESET;
      port4_function_select_low <= `UCR_P4_RESET;
      port4_function_select_high <= `UCR_P4_RESET;
    end else if (wr_i) begin
      if (hit(addr_i, `UCR_P4_DATA_OFS)) port4_output_data <= wdata_i;
      if (hit(addr_i, `UCR_P4_DIR_OFS)) port4_direction <= wdata_i;
      if (hit(addr_i, `UCR_P4_CON0_OFS)) port4_drive_config_low <= wdata_i;
      if (hit(addr_i, `UCR_P4_CON1_OFS)) port4_drive_config_high <= wdata_i;
      if (hit(addr_i, `UCR_P4_MOD0_OFS)) begin
        port4_function_select_low <= wdata_i;
      end
      if (hit(addr_i, `UCR_P4_MOD1_OFS)) begin
        port4_function_select_high <= wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port 5 registers: only bits 3..0 exist, upper bits read zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port5_output_data <= `UCR_P5_RESET;
      port5_direction <= `UCR_P5_DIR_RESET;
      port5_drive_config_low <= `UCR_P5_RESET;
      port5_drive_config_high <= `UCR_P5_RESET;
      port5_function_select_low <= `UCR_P5_RESET;
      port5_function_select_high <= `UCR_P5_RESET;
    end else if (wr_i) begin
      if (hit(addr_i, `UCR_P5_DATA_OFS)) begin
        port5_output_data <= wdata_i & `UCR_P5_MASK;
      end
      if (hit(addr_i, `UCR_P5_DIR_OFS)) begin
        port5_direction <= wdata_i & `UCR_P5_MASK;
      end
      if (hit(addr_i, `UCR_P5_CON0_OFS)) begin
        port5_drive_config_low <= wdata_i & `UCR_P5_MASK;
      end
      if (hit(addr_i, `UCR_P5_CON1_OFS)) begin
        port5_drive_config_high <= wdata_i & `UCR_P5_MASK;
      end
      if (hit(addr_i, `UCR_P5_MOD0_OFS)) begin
        port5_function_select_low <= wdata_i & `UCR_P5_MASK;
      end
      if (hit(addr_i, `UCR_P5_MOD1_OFS)) begin
        port5_function_select_high <= wdata_i & `UCR_P5_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit pin: fourth function carries the serial output
  // fourth function select
  // CMOS drive when drive 11, direction 0
  // port data bypassed on the alternate path
  ucr_pin_out u_tx_out (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .mode_hi_i(port5_function_select_high[TXB]),
    .mode_lo_i(port5_function_select_low[TXB]),
    .drive_hi_i(port5_drive_config_high[TXB]),
    .drive_lo_i(port5_drive_config_low[TXB]),
    .direction_i(port5_direction[TXB]),
    .port_data_i(port5_output_data[TXB]),
    .alt_data_i(serial0_transmit_line_i),
    .pin_o(tx_pad),
    .pin_oe_o(tx_pad_oe),
    .alt_sel_o(tx_sel)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive pin: mode 01 with direction set to input
  // receive routing on mode 01
  // direction must be input; drive bits unused
  ucr_pin_in u_rx_in (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(rx_pin_i),
    .mode_hi_i(port4_function_select_high[RXB]),
    .mode_lo_i(port4_function_select_low[RXB]),
    .direction_i(port4_direction[RXB]),
    .pin_sync_o(rx_pad_sync),
    .alt_line_o(rx_line),
    .alt_sel_o(rx_sel)
  );

  // the transmit pad is read back only for status
  ucr_pin_in u_tx_rb (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(tx_pin_i),
    .mode_hi_i(1'b0),
    .mode_lo_i(1'b0),
    .direction_i(1'b0),
    .pin_sync_o(tx_pin_sync),
    .alt_line_o(),
    .alt_sel_o()
  );

  ////////////////////////////////////////////////////////////////////////
  // pad outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_pin_o <= 1'b1;
      tx_pin_oe_o <= 1'b0;
    end else begin
      tx_pin_o <= tx_pad;
      tx_pin_oe_o <= tx_pad_oe;
    end
  end

  // port data never reaches the pad while receiving
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_pin_o <= 1'b1;
      rx_pin_oe_o <= 1'b0;
    end else begin
      rx_pin_o <= rx_sel ? 1'b1 : port4_output_data[RXB];
      rx_pin_oe_o <= ~rx_sel & ~port4_direction[RXB] &
        port4_drive_config_high[RXB] & port4_drive_config_low[RXB];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial0_receive_line_o <= 1'b1;
    end else begin
      serial0_receive_line_o <= rx_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the strobe, zero otherwise
  always_comb begin
    status = 8'h00;
    status[`UCR_ST_TX_ROUTED] = tx_sel;
    status[`UCR_ST_RX_ROUTED] = rx_sel;
    status[`UCR_ST_TX_DRIVE] = tx_pin_sync;
    status[`UCR_ST_RX_LINE] = rx_pad_sync;
  end

  always_comb begin
    case (addr_i)
      `UCR_P4_DATA_OFS: next_rdata = port4_output_data;
      `UCR_P4_DIR_OFS: next_rdata = port4_direction;
      `UCR_P4_CON0_OFS: next_rdata = port4_drive_config_low;
      `UCR_P4_CON1_OFS: next_rdata = port4_drive_config_high;
      `UCR_P4_MOD0_OFS: next_rdata = port4_function_select_low;
      `UCR_P4_MOD1_OFS: next_rdata = port4_function_select_high;
      `UCR_P5_DATA_OFS: next_rdata = port5_output_data;
      `UCR_P5_DIR_OFS: next_rdata = port5_direction;
      `UCR_P5_CON0_OFS: next_rdata = port5_drive_config_low;
      `UCR_P5_CON1_OFS: next_rdata = port5_drive_config_high;
      `UCR_P5_MOD0_OFS: next_rdata = port5_function_select_low;
      `UCR_P5_MOD1_OFS: next_rdata = port5_function_select_high;
      `UCR_STATUS_OFS: next_rdata = status;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end
endmodule : ucr_pin_route

// [rtl/ucr_params.svh]
// register offsets, field positions and reset values of the pin router
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH

`define UCR_ADDR_W 16
`define UCR_P4_DATA_OFS 16'hf220
`define UCR_P4_DIR_OFS 16'hf221
`define UCR_P4_CON0_OFS 16'hf222
`define UCR_P4_CON1_OFS 16'hf223
`define UCR_P4_MOD0_OFS 16'hf224
`define UCR_P4_MOD1_OFS 16'hf225
`define UCR_P5_DATA_OFS 16'hf228
`define UCR_P5_DIR_OFS 16'hf229
`define UCR_P5_CON0_OFS 16'hf22a
`define UCR_P5_CON1_OFS 16'hf22b
`define UCR_P5_MOD0_OFS 16'hf22c
`define UCR_P5_MOD1_OFS 16'hf22d
`define UCR_STATUS_OFS 16'hf230
`define UCR_TX_BIT 3
`define UCR_RX_BIT 2
`define UCR_P4_RESET 8'h00
`define UCR_P5_RESET 8'h00
`define UCR_P5_MASK 8'h0f
`define UCR_P5_DIR_RESET 8'h0f
`define UCR_P4_DIR_RESET 8'hff
`define UCR_ST_TX_ROUTED 0
`define UCR_ST_RX_ROUTED 1
`define UCR_ST_TX_DRIVE 2
`define UCR_ST_RX_LINE 3

`endif

// [rtl/ucr_pkg.sv]
// types shared by the pin router
package ucr_pkg;
  typedef enum logic [1:0] {
    UCR_FN_PORT,
    UCR_FN_SECOND,
    UCR_FN_THIRD,
    UCR_FN_FOURTH
  } ucr_func_t;

  typedef enum logic [1:0] {
    UCR_DRV_HIZ,
    UCR_DRV_OPEN_DRAIN_N,
    UCR_DRV_OPEN_DRAIN_P,
    UCR_DRV_CMOS
  } ucr_drive_t;
endpackage : ucr_pkg

// [rtl/ucr_pin_out.sv]
// output stage of one port pin: function select and drive mode
module ucr_pin_out (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic mode_hi_i,
  input wire logic mode_lo_i,
  input wire logic drive_hi_i,
  input wire logic drive_lo_i,
  input wire logic direction_i,
  input wire logic port_data_i,
  input wire logic alt_data_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic alt_sel_o
);
  ucr_pkg::ucr_func_t func;
  ucr_pkg::ucr_drive_t drv;
  logic level;

  always_comb begin
    func = ucr_pkg::ucr_func_t'({mode_hi_i, mode_lo_i});
    drv = ucr_pkg::ucr_drive_t'({drive_hi_i, drive_lo_i});
  end

  // port data feeds the pin unless the fourth function is chosen
  always_comb begin
    case (func)
      ucr_pkg::UCR_FN_FOURTH: level = alt_data_i;
      default: level = port_data_i;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 1'b1;
      pin_oe_o <= 1'b0;
      alt_sel_o <= 1'b0;
    end else begin
      alt_sel_o <= (func == ucr_pkg::UCR_FN_FOURTH);
      pin_o <= level;
      // direction 0 means output; open-drain drives only one level
      if (direction_i) begin
        pin_oe_o <= 1'b0;
      end else begin
        case (drv)
          ucr_pkg::UCR_DRV_CMOS: pin_oe_o <= 1'b1;
          ucr_pkg::UCR_DRV_OPEN_DRAIN_N: pin_oe_o <= ~level;
          ucr_pkg::UCR_DRV_OPEN_DRAIN_P: pin_oe_o <= level;
          default: pin_oe_o <= 1'b0;
        endcase
      end
    end
  end
endmodule : ucr_pin_out

// [rtl/ucr_pin_in.sv]
// input stage of one port pin: two-flop synchroniser and routing
module ucr_pin_in (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic mode_hi_i,
  input wire logic mode_lo_i,
  input wire logic direction_i,
  output logic pin_sync_o,
  output logic alt_line_o,
  output logic alt_sel_o
);
  logic meta;
  logic sel;

  always_comb begin
    sel = ~mode_hi_i & mode_lo_i & direction_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      pin_sync_o <= 1'b1;
    end else begin
      meta <= pin_i;
      pin_sync_o <= meta;
    end
  end

  // idle high when not selected so the receiver sees no false start bit
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alt_line_o <= 1'b1;
      alt_sel_o <= 1'b0;
    end else begin
      alt_sel_o <= sel;
      alt_line_o <= sel ? pin_sync_o : 1'b1;
    end
  end
endmodule : ucr_pin_in

// [verif/ucr_pin_route_sva.sv]
// port-level checks of the pin router
`include "ucr_params.svh"
module ucr_pin_route_sva #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial0_transmit_line_i,
  input wire logic serial0_receive_line_o,
  input wire logic tx_pin_i,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_o,
  input wire logic rx_pin_i,
  input wire logic rx_pin_o,
  input wire logic rx_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m5h, m5l, c5h, c5l, d5, m4h, m4l, d4, ok4, ok6;
  logic [2:0] age;
  // shadow of the routing bits, rebuilt from the bus writes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {m5h, m5l, c5h, c5l, m4h, m4l} <= 6'h00;
      {d5, d4} <= 2'h3;
    end else if (wr_i) begin
      case (addr_i)
        `UCR_P5_MOD1_OFS: m5h <= wdata_i[3];
        `UCR_P5_MOD0_OFS: m5l <= wdata_i[3];
        `UCR_P5_CON1_OFS: c5h <= wdata_i[3];
        `UCR_P5_CON0_OFS: c5l <= wdata_i[3];
        `UCR_P5_DIR_OFS: d5 <= wdata_i[3];
        `UCR_P4_MOD1_OFS: m4h <= wdata_i[2];
        `UCR_P4_MOD0_OFS: m4l <= wdata_i[2];
        `UCR_P4_DIR_OFS: d4 <= wdata_i[2];
        default: ;
      endcase
    end
  end
  // cycles since the last write, so the pipeline has settled
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      age <= 3'h0;
    end else if (wr_i) begin
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  assign ok4 = age >= 3'h4;
  assign ok6 = age >= 3'h6;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_TX_FOLLOW: assert property (
    ok4 && m5h && m5l |-> tx_pin_o == $past(serial0_transmit_line_i, 2))
    else $error("tx pad not following transmitter");
  AST_TX_CMOS: assert property (
    ok4 && c5h && c5l && !d5 |-> tx_pin_oe_o)
    else $error("tx pad not driving");
  AST_RX_FOLLOW: assert property (
    ok6 && !m4h && m4l && d4 |-> serial0_receive_line_o == $past(rx_pin_i, 4))
    else $error("receive line not following pad");
  AST_RX_IDLE: assert property (
    ok4 && !(!m4h && m4l && d4) |-> serial0_receive_line_o)
    else $error("receive line not idle");
  AST_RX_HIZ: assert property (
    ok4 && !m4h && m4l && d4 |-> !rx_pin_oe_o)
    else $error("receive pad driven");
  AST_RDATA_PULSE: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  cover property (ok4 && m5h && m5l && c5h && c5l && !d5);
  cover property (ok6 && m4l && $fell(serial0_receive_line_o));
  cover property ($past(rd_i) && rdata_o != 8'h00);
endmodule : ucr_pin_route_sva

// [verif/ucr_serial_model.sv]
// serial engine stand-in: rotates a bit pattern onto its transmit line
module ucr_serial_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] pattern_i,
  output logic tx_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] idx;
  // held high during reset like an idle transmitter, then sends the pattern
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx <= 3'h0;
      tx_line_o <= 1'b1;
    end else begin
      idx <= idx + 3'h1;
      tx_line_o <= pattern_i[idx];
    end
  end
endmodule : ucr_serial_model

// [verif/ucr_pin_route_tb.sv]
// self-checking bench of the pin router
`include "ucr_params.svh"
module ucr_pin_route_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, rst_i, wr_i, rd_i, tx_line, rx_line, rx_drv;
  logic tx_pin_i, tx_pin_o, tx_pin_oe_o, rx_pin_i, rx_pin_o, rx_pin_oe_o;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pat, cnt;
  logic [4:0] txh, rxh;
  int fail_count, compares, k;
  // pull-up on the tx pad; the bench is the far end of the rx pad
  assign tx_pin_i = tx_pin_oe_o ? tx_pin_o : 1'b1;
  assign rx_pin_i = rx_pin_oe_o ? rx_pin_o : rx_drv;
  ucr_pin_route ucr_pin_route_inst (.sys_clk_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .serial0_transmit_line_i(tx_line),
    .serial0_receive_line_o(rx_line), .tx_pin_i, .tx_pin_o, .tx_pin_oe_o,
    .rx_pin_i, .rx_pin_o, .rx_pin_oe_o);
  ucr_serial_model ucr_serial_model_inst (.sys_clk_i, .rst_i,
    .pattern_i(pat), .tx_line_o(tx_line));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // pad stimulus toggles in a fixed pattern once reset is released
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      rx_drv <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      rx_drv <= cnt[2] ^ cnt[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
    @(posedge sys_clk_i);
  endtask : rd
  // tx pad lags the engine by 2 edges, receive line lags the pad by 4
  task automatic watch(input int n, input logic tx_on, input logic rx_on);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk_i);
      txh = {txh[3:0], tx_line};
      rxh = {rxh[3:0], rx_pin_i};
      if (i > 5 && tx_on) chk("tx_pin", {7'h0, txh[2]}, {7'h0, tx_pin_o});
      if (i > 5) chk("rx_line", {7'h0, !rx_on | rxh[4]}, {7'h0, rx_line});
    end
    @(posedge sys_clk_i);
  endtask : watch
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = {3'h4, 24'h0};
    {pat, txh, rxh, fail_count, compares} = 0;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 chk("tx_oe", 8'h00, {7'h0, tx_pin_oe_o});
    @(posedge sys_clk_i);
    for (k = 0; k < 14; k++) begin
      rd(16'hf220 + k[15:0], (k == 1) ? 8'hff : (k == 9) ? 8'h0f : 8'h00);
    end
    wr(`UCR_P5_DATA_OFS, 8'hff);
    rd(`UCR_P5_DATA_OFS, 8'h0f);
    watch(10, 1'b0, 1'b0);
    $display("test reset and map done");
    pat <= 8'h5c;
    wr(`UCR_P5_MOD1_OFS, 8'h08);
    wr(`UCR_P5_MOD0_OFS, 8'h08);
    wr(`UCR_P5_CON1_OFS, 8'h08);
    wr(`UCR_P5_CON0_OFS, 8'h08);
    wr(`UCR_P5_DIR_OFS, 8'h00);
    watch(20, 1'b1, 1'b0);
    #1 chk("tx_oe", 8'h01, {7'h0, tx_pin_oe_o});
    @(posedge sys_clk_i);
    wr(`UCR_P5_DATA_OFS, 8'h00);
    watch(14, 1'b1, 1'b0);
    wr(`UCR_P5_DATA_OFS, 8'h08);
    watch(14, 1'b1, 1'b0);
    $display("test transmit done");
    wr(`UCR_P4_MOD0_OFS, 8'h04);
    watch(20, 1'b1, 1'b1);
    #1 chk("rx_oe", 8'h00, {7'h0, rx_pin_oe_o});
    chk("rx_pin", 8'h01, {7'h0, rx_pin_o});
    @(posedge sys_clk_i);
    wr(`UCR_P4_DATA_OFS, 8'h04);
    wr(`UCR_P4_CON1_OFS, 8'h04);
    watch(14, 1'b1, 1'b1);
    wr(`UCR_P4_MOD1_OFS, 8'h04);
    watch(14, 1'b1, 1'b0);
    $display("test receive done");
    // rx pad as plain output, tx pad open-drain with the line held high
    pat <= 8'hff;
    wr(`UCR_P4_DATA_OFS, 8'h00);
    wr(`UCR_P4_CON0_OFS, 8'h04);
    wr(`UCR_P4_DIR_OFS, 8'h00);
    wr(`UCR_P5_CON1_OFS, 8'h00);
    repeat (8) @(posedge sys_clk_i);
    #1 chk("rx_pin", 8'h00, {7'h0, rx_pin_o});
    chk("rx_oe", 8'h01, {7'h0, rx_pin_oe_o});
    chk("tx_oe", 8'h00, {7'h0, tx_pin_oe_o});
    @(posedge sys_clk_i);
    rd(`UCR_STATUS_OFS, 8'h05);
    $display("test pad drive done");
    report_and_stop();
  end
endmodule : ucr_pin_route_tb

bind ucr_pin_route ucr_pin_route_sva #(.ADDR_W(ADDR_W)) ucr_pin_route_sva_inst (
  .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .serial0_transmit_line_i, .serial0_receive_line_o, .tx_pin_i, .tx_pin_o,
  .tx_pin_oe_o, .rx_pin_i, .rx_pin_o, .rx_pin_oe_o);
